// [include/touch_adc_map.svh]
// offsets, field positions, reset values and timing counts of the touch converter
`ifndef TOUCH_ADC_MAP_SVH
`define TOUCH_ADC_MAP_SVH

// register byte offsets
`define RESULT_OFFSET   12'h000
`define DIVIDER_OFFSET  12'h004
`define STATUS_OFFSET   12'h008
`define MASK_OFFSET     12'h00c

// field positions
`define DONE_FLAG_BIT   31
`define DIV_SELECT_BIT  16
`define EV_DONE_BIT     0
`define EV_MISS_BIT     1
`define STATE_LSB       8

// reset values
`define DIVIDER_RESET   32'h0000_0000
`define MASK_RESET      2'h0
`define SAMPLE_RESET    16'h0000

// reference divide ratios and conversion length in converter clocks
`define REF_DIV_FAST    4'h4
`define REF_DIV_SLOW    5'h10
`define SETTLE_TICKS    8'h10
`define CONVERT_TICKS   8'h11

`endif

// [include/touch_adc_pkg.sv]
// types shared by the touch converter design
package touch_adc_pkg;

   typedef logic [15:0] sample_t;
   typedef logic [31:0] word_t;
   typedef logic [11:0] addr_t;

   // gray along idle -> settle -> convert -> done; done -> settle flips both bits
   typedef enum logic [1:0] {
      st_idle    = 2'b00,
      st_settle  = 2'b01,
      st_convert = 2'b11,
      st_done    = 2'b10
   } conv_state_e;

endpackage

// [verilog/adc_clock_divider.sv]
// converter clock enable derived from the external reference pin
`timescale 1ns/1ns
`include "touch_adc_map.svh"

module adc_clock_divider (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ref_clk_pin,
   input  wire logic slow_select,
   output logic      conv_tick
);

   logic       ref_meta;
   logic       ref_sync;
   logic       ref_last;
   logic [4:0] edge_count;
   wire        ref_rise;
   wire  [4:0] limit;
   wire        wrap;

   // divide ratio from the select bit
   assign limit    = slow_select ? `REF_DIV_SLOW : {1'b0, `REF_DIV_FAST};
   assign ref_rise = ref_sync & ~ref_last;
   assign wrap     = ref_rise && (edge_count >= limit - 5'h01);

   // two-flop synchroniser, then edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         ref_last <= 1'b0;
      end else begin
         ref_meta <= ref_clk_pin;
         ref_sync <= ref_meta;
         ref_last <= ref_sync;
      end
   end

   // count reference edges, one pulse per 4 or 16
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_count <= 5'h00;
         conv_tick  <= 1'b0;
      end else begin
         conv_tick <= wrap; // R07
         if (wrap) begin
            edge_count <= 5'h00;
         end else if (ref_rise) begin
            edge_count <= edge_count + 5'h01;
         end
      end
   end

endmodule

// [verilog/touch_adc_read_trigger.sv]
// touch converter control: read-triggered conversion engine behind an apb slave
//
// Overview of operation
// R01 - A processor read of the result register starts a new conversion.
// R02 - Bit 31 of the result word is the completion flag; software rereads while it is zero.
// R03 - The sample sits in the low sixteen bits and software masks the rest away.
// R04 - In signed mode software sign-extends the low halfword itself.
// R05 - A result read during a running conversion leaves that conversion untouched.
// R06 - Bit 16 of the divider register selects the converter clock rate.
// R07 - Clear selects the reference divided by 4, set selects it divided by 16.
// R08 - Software waits between conversions to keep 3750 or 925 samples per second.
// R09 - The flag clears when a conversion begins and sets once the sample is stored.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
`include "touch_adc_map.svh"

module touch_adc_read_trigger (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire touch_adc_pkg::addr_t   paddr,
   input  wire touch_adc_pkg::word_t   pwdata,
   output touch_adc_pkg::word_t        prdata,
   output logic                        pready,
   output logic                        pslverr,
   output logic                        irq,
   input  wire logic                   ref_clk_pin,
   input  wire touch_adc_pkg::sample_t adc_sample,
   output logic                        adc_hold,
   output logic                        adc_convert
);
   import touch_adc_pkg::*;

   conv_state_e state;
   conv_state_e next_state;
   logic [7:0]  tick_count;
   logic [7:0]  next_tick_count;
   sample_t     sample;
   sample_t     sample_meta;
   sample_t     sample_sync;
   logic        div_select;
   logic [1:0]  status;
   logic [1:0]  mask;
   logic        conv_tick;

   wire         prep;
   wire         take_wr;
   wire         hit_result;
   wire         hit_divider;
   wire         hit_status;
   wire         hit_mask;
   wire         hit_any;
   wire         result_read;
   wire         can_start;
   wire         start;
   wire         missed;
   wire         finish;
   wire         settle_end;
   word_t       result_word;
   word_t       divider_word;
   word_t       status_word;
   word_t       mask_word;
   word_t       read_mux;
   wire  [1:0]  events;
   wire  [1:0]  next_status;

   // converter clock enable from the reference pin
   adc_clock_divider u_divider (
      .pclk        (pclk),
      .presetn     (presetn),
      .ref_clk_pin (ref_clk_pin),
      .slow_select (div_select),
      .conv_tick   (conv_tick)
   );

   // bus phases: prep is the first access cycle, take_wr the completing one
   assign prep    = psel & penable & ~pready;
   assign take_wr = psel & penable & pready & pwrite;

   // address decode
   assign hit_result  = (paddr == `RESULT_OFFSET);
   assign hit_divider = (paddr == `DIVIDER_OFFSET);
   assign hit_status  = (paddr == `STATUS_OFFSET);
   assign hit_mask    = (paddr == `MASK_OFFSET);
   assign hit_any     = hit_result | hit_divider | hit_status | hit_mask;

   // conversion start and refusal
   assign result_read = prep & ~pwrite & hit_result;
   assign can_start   = (state == st_idle) || (state == st_done);
   assign start       = result_read & can_start;  // R01
   assign missed      = result_read & ~can_start; // R05
   assign settle_end  = conv_tick && (tick_count == `SETTLE_TICKS - 8'h01);
   assign finish      = (state == st_convert) && conv_tick
                        && (tick_count == `CONVERT_TICKS - 8'h01);

   // read words
   // flag follows the engine state, so a restart clears it at once
   assign result_word  = {(state == st_done), 15'h0000, sample}; // R02 R03
   assign divider_word = {15'h0000, div_select, 16'h0000};      // R06
   assign status_word  = {22'h000000, state, 6'h00, status};
   assign mask_word    = {30'h00000000, mask};
   assign read_mux     = hit_result  ? result_word  :
                         hit_divider ? divider_word :
                         hit_status  ? status_word  :
                         hit_mask    ? mask_word    : 32'h0000_0000;

   // sticky events, a new event beats a write-one clear
   assign events      = {missed, finish};
   assign next_status = (status & ~((take_wr & hit_status) ? pwdata[1:0] : 2'h0))
                        | events;

   // conversion engine next state
   always_comb begin
      next_state      = state;
      next_tick_count = tick_count;
      unique case (state)
         st_idle, st_done: begin
            if (start) begin
               next_state      = st_settle; // R09
               next_tick_count = 8'h00;
            end
         end
         st_settle: begin
            if (settle_end) begin
               next_state      = st_convert;
               next_tick_count = 8'h00;
            end else if (conv_tick) begin
               next_tick_count = tick_count + 8'h01;
            end
         end
         st_convert: begin
            if (finish) begin
               next_state      = st_done; // R09
               next_tick_count = 8'h00;
            end else if (conv_tick) begin
               next_tick_count = tick_count + 8'h01;
            end
         end
      endcase
   end

   // engine state and front-end strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= st_idle;
         tick_count  <= 8'h00;
         adc_hold    <= 1'b0;
         adc_convert <= 1'b0;
      end else begin
         state       <= next_state;
         tick_count  <= next_tick_count;
         adc_hold    <= (next_state == st_settle);
         adc_convert <= (next_state == st_convert);
      end
   end

   // front-end sample through two flops, held stable during conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_meta <= `SAMPLE_RESET;
         sample_sync <= `SAMPLE_RESET;
      end else begin
         sample_meta <= adc_sample;
         sample_sync <= sample_meta;
      end
   end

   // result field loads only when the conversion completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample <= `SAMPLE_RESET;
      end else if (finish) begin
         sample <= sample_sync; // R09
      end
   end

   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // only the select bit of the divider reset value is kept
         div_select <= 1'(`DIVIDER_RESET >> `DIV_SELECT_BIT);
         mask       <= `MASK_RESET;
         status     <= 2'h0;
      end else begin
         status <= next_status;
         if (take_wr & hit_divider) begin
            div_select <= pwdata[`DIV_SELECT_BIT]; // R06
         end
         if (take_wr & hit_mask) begin
            mask <= pwdata[1:0];
         end
      end
   end

   // apb answer: one wait cycle, then registered data
   // a result read returns the word from before its own trigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= prep;
         pslverr <= prep & ~hit_any;
         if (prep) begin
            prdata <= pwrite ? 32'h0000_0000 : read_mux;
         end
      end
   end

   // level interrupt from unmasked sticky events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_status & mask);
      end
   end

endmodule

// [verification/touch_adc_read_trigger_asserts.sv]
// port checker for the touch converter
`timescale 1ns/1ns
`include "touch_adc_map.svh"
module touch_adc_read_trigger_chk (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire touch_adc_pkg::addr_t paddr,
   input wire touch_adc_pkg::word_t pwdata,
   input wire touch_adc_pkg::word_t prdata,
   input wire logic                 pready,
   input wire logic                 adc_hold,
   input wire logic                 adc_convert
);
   import touch_adc_pkg::*;
   localparam int FAST = 1156; // 17 ticks of 68 pclk
   localparam int SLOW = 4624; // 17 ticks of 272 pclk
   logic slow;
   int   cnt;
   int   lo;
   wire  rd   = psel && penable && !pwrite && paddr == `RESULT_OFFSET;
   wire  busy = adc_hold || adc_convert;
   wire  wdiv = psel && penable && pready && pwrite && paddr == `DIVIDER_OFFSET;
   assign lo = slow ? SLOW - 2 : FAST - 2;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // divider select and convert length tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow <= 1'b0;
         cnt  <= 0;
      end else begin
         slow <= wdiv ? pwdata[`DIV_SELECT_BIT] : slow;
         cnt  <= adc_convert ? cnt + 1 : 0;
      end
   end
   AST_READ_STARTS: assert property (rd && !pready && !busy |-> ##[1:2] adc_hold)
      else $error("read did not start");
   AST_BUSY_FLAG: assert property (rd && pready && busy && $past(busy) |-> !prdata[31])
      else $error("flag set while busy");
   AST_NO_RESTART: assert property (rd && !pready && adc_convert |=> !adc_hold)
      else $error("busy read restarted");
   AST_HOLD_KEEPS: assert property (rd && !pready && adc_hold |=> busy)
      else $error("busy read aborted");
   AST_UPPER_ZERO: assert property (rd && pready |-> prdata[30:16] == 15'h0)
      else $error("upper bits set");
   AST_CONV_LEN: assert property ($fell(adc_convert) |-> cnt inside {[lo:lo+4]})
      else $error("convert length off");
   AST_HOLD_TO_CONV: assert property ($fell(adc_hold) |-> adc_convert)
      else $error("settle not followed by convert");
   AST_CONV_FROM_HOLD: assert property ($rose(adc_convert) |-> $past(adc_hold))
      else $error("convert without settle");
   AST_ACCESS_ENDS: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("access length off");
   cover property (rd && pready && prdata[31]);
   cover property ($fell(adc_convert) && slow);
   cover property (rd && !pready && adc_convert);
endmodule

bind touch_adc_read_trigger touch_adc_read_trigger_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .adc_hold(adc_hold), .adc_convert(adc_convert));

// [verification/touch_front_end.sv]
// analog front end and reference oscillator model
`timescale 1ns/1ns
module touch_front_end (
   input  wire logic                   adc_convert,
   input  wire touch_adc_pkg::sample_t value,
   output logic                        ref_clk_pin,
   output touch_adc_pkg::sample_t      adc_sample
);
   import touch_adc_pkg::*;
   // free running reference, rounded to 68 ns
   initial begin
      ref_clk_pin = 1'b0;
      #1; // keep reference edges off the pclk edges
      forever #34 ref_clk_pin = !ref_clk_pin;
   end
   // value valid only while converting
   assign adc_sample = adc_convert ? value : ~value;
endmodule

// [verification/touch_adc_read_trigger_test.sv]
// self-checking bench for the touch converter
`timescale 1ns/1ns
`include "touch_adc_map.svh"
module touch_adc_read_trigger_test;
   import touch_adc_pkg::*;
   typedef struct {word_t exp; word_t msk; logic err;} note_s;
   logic    pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic    ref_clk_pin, adc_hold, adc_convert;
   addr_t   paddr;
   word_t   pwdata, prdata, rq;
   sample_t adc_sample, value, prev;
   note_s   notes[$];
   int      n_mismatch, checks_done, k;
   touch_adc_read_trigger DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .ref_clk_pin(ref_clk_pin),
      .adc_sample(adc_sample), .adc_hold(adc_hold), .adc_convert(adc_convert));
   touch_front_end fe (.adc_convert(adc_convert), .value(value), .ref_clk_pin(ref_clk_pin),
      .adc_sample(adc_sample));
   // 250 mhz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = !pclk;
   end
   task automatic check(input word_t seen, input word_t exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one apb transfer; bb keeps psel up for a following setup
   task automatic xfer(input logic w, input addr_t a, input word_t d, input word_t m,
                       input word_t e, input logic bb);
      if (!w) notes.push_back('{e, m, a > `MASK_OFFSET});
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rq = prdata;
      if (!bb) begin
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task automatic irq_is(input logic e);
      repeat (2) @(posedge pclk);
      #1 check(word_t'(irq), word_t'(e));
      @(posedge pclk);
   endtask
   // compares each completed read with the oldest note
   always @(posedge pclk) begin
      note_s n;
      if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
         n = notes.pop_front();
         check(prdata & n.msk, n.exp & n.msk);
         check(word_t'(pslverr), word_t'(n.err));
      end
   end
   // watchdog
   initial begin
      #240000;
      n_mismatch++;
      complete_run();
   end
   // main sequence: reset, reset values, one conversion pair per divider setting
   initial begin
      void'($urandom(32'hb2aa));
      {presetn, psel, penable, pwrite, paddr, pwdata, value} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(0, `DIVIDER_OFFSET, 0, '1, `DIVIDER_RESET, 0);
      xfer(0, `MASK_OFFSET, 0, '1, 0, 0);
      xfer(0, 12'h010, 0, '1, 0, 0);
      for (int s = 0; s < 2; s++) begin
         xfer(1, `DIVIDER_OFFSET, word_t'(s) << 16, 0, 0, 0);
         xfer(0, `DIVIDER_OFFSET, 0, '1, word_t'(s) << 16, 0);
         prev = value;
         value <= sample_t'($urandom);
         xfer(0, `RESULT_OFFSET, 0, 32'h8000_ffff, {s > 0, 15'h0, prev}, 1);
         xfer(0, `RESULT_OFFSET, 0, 32'h8000_0000, 0, 0);
         // poll until a finished sample is reported
         for (k = 0; k < 300 && rq[31] !== 1'b1; k++) begin
            repeat (50) @(posedge pclk);
            xfer(0, `RESULT_OFFSET, 0, 32'h7fff_0000, 0, 0);
         end
         check(word_t'(rq[31]), 32'h0000_0001);
         check(rq & 32'hffff, word_t'(value));
         check({{16{rq[15]}}, rq[15:0]}, {{16{value[15]}}, value});
         // pause until the restarted engine is done
         for (k = 0; k < 12000 && (adc_hold || adc_convert); k++) @(posedge pclk);
         check(word_t'(adc_hold || adc_convert), 32'h0000_0000);
         xfer(0, `STATUS_OFFSET, 0, '1, 32'h0000_0203, 0);
         irq_is(1'b0);
         xfer(1, `MASK_OFFSET, 32'h1, 0, 0, 0);
         irq_is(1'b1);
         xfer(1, `STATUS_OFFSET, 32'h3, 0, 0, 0);
         irq_is(1'b0);
         xfer(0, `STATUS_OFFSET, 0, '1, 32'h0000_0200, 0);
         xfer(1, `MASK_OFFSET, 32'h0, 0, 0, 0);
      end
      complete_run();
   end
endmodule
